// >>> src/strap_ctrl.sv
// Strap sampling, mode selection and persistent command settings
`timescale 1ns/100ps
module strap_ctrl
	import strap_ctrl_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic        I_BOOT_SOURCE_SELECT,
	input  wire logic        I_EXTERNAL_REF_SELECT,
	input  wire logic        I_PULSE_REF_SELECT,
	input  wire logic        I_HOLDOVER_FORCE,
	input  wire logic [3:0]  I_ADDR,
	input  wire logic [31:0] I_WDATA,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	output logic      [31:0] O_RDATA,
	input  wire logic [95:0] I_NV_DATA,
	output logic      [95:0] O_NV_DATA,
	output logic             O_NV_WRITE,
	input  wire logic        I_NV_DONE,
	output logic             O_BOOT_FROM_ROM,
	output logic             O_USE_EXT_REF,
	output logic             O_USE_EXT_PULSE,
	output logic             O_HOLDOVER,
	output logic             O_CORE_RESET_N,
	output logic      [31:0] O_BAUD,
	output logic      [31:0] O_MSGSET,
	output logic      [31:0] O_FREQ
);
	strap_sync_if sync ();

	logic [31:0] param_r [PARAM_NUM];
	logic        boot_rom_r;
	logic        ext_ref_r;
	logic        ext_pulse_r;
	logic        holdover_r;
	logic        restored_r;
	logic        nv_write_r;
	logic [31:0] rdata_r;
	nv_state_e   nv_state_r;
	logic        save_busy;

	// ****************************************
	// Command decoding
	// ****************************************
	// Only the three setting slots hold storage; status ignores writes and a write to save only starts a commit
	function automatic logic is_param_addr(input logic [3:0] addr);
		is_param_addr = (addr == ADDR_BAUD) || (addr == ADDR_MSGSET)
			|| (addr == ADDR_FREQ);
	endfunction

	// Setting slots sit at the bottom of the map, so the low bits index the store
	function automatic logic [1:0] param_slot(input logic [3:0] addr);
		param_slot = addr[1:0];
	endfunction

	function automatic logic [31:0] status_word
	(
		input logic boot_rom,
		input logic ext_ref,
		input logic ext_pulse,
		input logic holdover,
		input logic restored,
		input logic busy
	);
		logic [31:0] word;
		word               = 32'h0;
		word[ST_BOOT_ROM]  = boot_rom;
		word[ST_EXT_REF]   = ext_ref;
		word[ST_EXT_PULSE] = ext_pulse;
		word[ST_HOLDOVER]  = holdover;
		word[ST_RESTORED]  = restored;
		word[ST_SAVE_BUSY] = busy;
		status_word        = word;
	endfunction

	// internal reset follows the pin through the synchroniser
	strap_sync u_sync
	(
		.i_clk     (I_CLK),
		.i_reset_n (I_RESET_N),
		.i_pins    ({I_HOLDOVER_FORCE, I_PULSE_REF_SELECT,
			I_EXTERNAL_REF_SELECT, I_BOOT_SOURCE_SELECT}),
		.sync      (sync.src)
	);

	// ****************************************
	// Straps caught at reset release
	// ****************************************
	// Boot and reference choices are frozen after release; changing the
	// reference pin while running would disturb the disciplining loop.
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			boot_rom_r <= 1'b0;
			ext_ref_r  <= 1'b0;
		end
		else if (!sync.rst_n)
		begin
			// Taken on both edges of the release window; the later one stands
			// low selects ROM boot
			boot_rom_r <= ~sync.boot_source_select;
			ext_ref_r  <= ~sync.external_ref_select;
		end
	end

	// ****************************************
	// Live mode pins
	// ****************************************
	// These two stay live, so the host may switch them while running
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			ext_pulse_r <= 1'b0;
			holdover_r  <= 1'b0;
		end
		else
		begin
			ext_pulse_r <= ~sync.pulse_ref_select;
			holdover_r  <= ~sync.holdover_force;
		end
	end

	// ****************************************
	// Parameter store and persistence
	// ****************************************
	// Reset defaults only matter until the stored image is read back
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			nv_state_r <= NV_LOAD;
			restored_r <= 1'b0;
			nv_write_r <= 1'b0;
			param_r[0] <= BAUD_RST;
			param_r[1] <= MSGSET_RST;
			param_r[2] <= FREQ_RST;
		end
		else if (!sync.rst_n)
		begin
			// Stay in load until the core reset lifts
			nv_state_r <= NV_LOAD;
			nv_write_r <= 1'b0;
		end
		else
		begin
			unique case (nv_state_r)
				NV_LOAD:
				begin
					// The image is taken once, in the first cycle after the core reset lifts
					// restore saved settings at start
					for (int i = 0; i < PARAM_NUM; i++)
						param_r[i] <= I_NV_DATA[i*32 +: 32];
					restored_r <= 1'b1;
					nv_state_r <= NV_RUN;
				end
				NV_RUN:
				begin
					if (I_WR && is_param_addr(I_ADDR))
						param_r[param_slot(I_ADDR)] <= I_WDATA;
					// One commit per request; further writes are dropped until it is confirmed
					if (I_WR && I_ADDR == ADDR_SAVE)
					begin
						nv_write_r <= 1'b1;
						nv_state_r <= NV_SAVE;
					end
				end
				NV_SAVE:
				begin
					// Writes are dropped here so the stored image matches the committed one
					nv_write_r <= 1'b0;
					if (I_NV_DONE)
						nv_state_r <= NV_RUN;
				end
			endcase
		end
	end

	// ****************************************
	// Read port
	// ****************************************
	// Zero outside the answer cycle, so a late sample never sees stale data
	always_ff @(posedge I_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
			rdata_r <= 32'h0;
		else if (I_RD)
		begin
			unique case (I_ADDR)
				ADDR_BAUD, ADDR_MSGSET, ADDR_FREQ:
					rdata_r <= param_r[param_slot(I_ADDR)];
				ADDR_STATUS:
					rdata_r <= status_word(boot_rom_r, ext_ref_r, ext_pulse_r, holdover_r,
						restored_r, save_busy);
				default:
					rdata_r <= 32'h0;
			endcase
		end
		else
			rdata_r <= 32'h0;
	end

	assign save_busy       = (nv_state_r == NV_SAVE);
	assign O_RDATA         = rdata_r;
	assign O_NV_WRITE      = nv_write_r;
	// Storage always sees the live settings; the commit pulse picks the moment
	assign O_NV_DATA       = {param_r[2], param_r[1], param_r[0]};
	assign O_BOOT_FROM_ROM = boot_rom_r;
	assign O_USE_EXT_REF   = ext_ref_r;
	assign O_USE_EXT_PULSE = ext_pulse_r;
	assign O_HOLDOVER      = holdover_r;
	assign O_CORE_RESET_N  = sync.rst_n;
	assign O_BAUD          = param_r[0];
	assign O_MSGSET        = param_r[1];
	assign O_FREQ          = param_r[2];
endmodule

// >>> src/strap_ctrl_pkg.sv
// Constants and types for the strap and mode control block
package strap_ctrl_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ           = 25000000;
	localparam int RESET_MIN_NS     = 1000;
	localparam int RESET_MIN_CYCLES = (RESET_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int SYNC_STAGES      = 2;

	// ****************************************
	// Command port layout
	// ****************************************
	localparam logic [3:0] ADDR_BAUD   = 4'h0;
	localparam logic [3:0] ADDR_MSGSET = 4'h1;
	localparam logic [3:0] ADDR_FREQ   = 4'h2;
	localparam logic [3:0] ADDR_STATUS = 4'h3;
	localparam logic [3:0] ADDR_SAVE   = 4'h4;
	localparam int         PARAM_NUM   = 3;

	localparam logic [31:0] BAUD_RST   = 32'h00009600;
	localparam logic [31:0] MSGSET_RST = 32'h000000ff;
	localparam logic [31:0] FREQ_RST   = 32'h00989680;

	localparam int ST_BOOT_ROM  = 0;
	localparam int ST_EXT_REF   = 1;
	localparam int ST_EXT_PULSE = 2;
	localparam int ST_HOLDOVER  = 3;
	localparam int ST_RESTORED  = 4;
	localparam int ST_SAVE_BUSY = 5;

	typedef enum logic [2:0]
	{
		NV_LOAD = 3'b001,
		NV_RUN  = 3'b010,
		NV_SAVE = 3'b100
	} nv_state_e;

endpackage

// >>> src/strap_sync_if.sv
// Synchronised strap levels passed from the synchroniser to the control logic
`timescale 1ns/100ps
interface strap_sync_if;
	logic boot_source_select;
	logic external_ref_select;
	logic pulse_ref_select;
	logic holdover_force;
	logic rst_n;
	modport src (output boot_source_select, external_ref_select, pulse_ref_select,
		holdover_force, rst_n);
	modport dst (input boot_source_select, external_ref_select, pulse_ref_select,
		holdover_force, rst_n);
endinterface

// >>> src/strap_sync.sv
// Two-stage synchronisers for strap pins and reset release
`timescale 1ns/100ps
module strap_sync
	import strap_ctrl_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_reset_n,
	input  wire logic  [3:0] i_pins,
	strap_sync_if.src  sync
);
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic [1:0] rst_r;

	// ****************************************
	// Level synchronisers
	// ****************************************
	// No reset: the pins keep flowing while reset is held, so the straps
	// have settled by the time the release window samples them
	// synchronise mode pins
	always_ff @(posedge i_clk)
	begin
		meta_r <= i_pins;
		sync_r <= meta_r;
	end

	// Reset asserts at once, releases through two flops to avoid a ragged release
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			rst_r <= 2'h0;
		else
			rst_r <= {rst_r[0], 1'b1};
	end

	assign sync.boot_source_select  = sync_r[0];
	assign sync.external_ref_select = sync_r[1];
	assign sync.pulse_ref_select    = sync_r[2];
	assign sync.holdover_force      = sync_r[3];
	assign sync.rst_n               = rst_r[1];
endmodule

// >>> verification/strap_ctrl_props.sv
// Concurrent checks on the strap control ports
`timescale 1ns/100ps
module strap_ctrl_props (
	input  wire logic        I_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic        I_PULSE_REF_SELECT,
	input  wire logic        I_HOLDOVER_FORCE,
	input  wire logic [3:0]  I_ADDR,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	input  wire logic [31:0] O_RDATA,
	input  wire logic        O_NV_WRITE,
	input  wire logic        O_BOOT_FROM_ROM,
	input  wire logic        O_USE_EXT_REF,
	input  wire logic        O_USE_EXT_PULSE,
	input  wire logic        O_HOLDOVER,
	input  wire logic        O_CORE_RESET_N
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);
	property p_rd_idle; !$past(I_RD) |-> O_RDATA == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_rd_gap; I_RD && I_ADDR > 4'h4 |=> O_RDATA == 32'h0; endproperty
	a_rd_gap: assert property (p_rd_gap) else $error("unmapped read not zero");
	property p_nv_one; O_NV_WRITE |=> !O_NV_WRITE; endproperty
	a_nv_one: assert property (p_nv_one) else $error("commit pulse too long");
	property p_nv_cause; O_NV_WRITE |-> $past(I_WR && I_ADDR == 4'h4); endproperty
	a_nv_cause: assert property (p_nv_cause) else $error("commit without save");
	property p_hold; $past(O_CORE_RESET_N, 2) |-> O_HOLDOVER == !$past(I_HOLDOVER_FORCE, 3);
	endproperty
	a_hold: assert property (p_hold) else $error("holdover not following pin");
	property p_pls; $past(O_CORE_RESET_N, 2) |-> O_USE_EXT_PULSE == !$past(I_PULSE_REF_SELECT, 3);
	endproperty
	a_pls: assert property (p_pls) else $error("pulse select not following pin");
	property p_frozen; O_CORE_RESET_N && $past(O_CORE_RESET_N) |->
		$stable(O_BOOT_FROM_ROM) && $stable(O_USE_EXT_REF); endproperty
	a_frozen: assert property (p_frozen) else $error("straps moved after reset");
	property p_core; $rose(I_RESET_N) |-> !O_CORE_RESET_N [*2] ##1 O_CORE_RESET_N; endproperty
	a_core: assert property (p_core) else $error("core reset release late");
endmodule

// >>> verification/nv_store_model.sv
// Settings storage model, slow to confirm a commit
`timescale 1ns/100ps
module nv_store_model (
	input  wire logic        i_clk,
	input  wire logic        i_write,
	input  wire logic [95:0] i_data,
	output logic      [95:0] o_data,
	output logic             o_done
);
	int cnt = 0;
	initial o_data = {32'h00000064, 32'h0000000f, 32'h00004b00};
	initial o_done = 1'b0;
	always @(posedge i_clk)
	begin
		o_done <= (cnt == 1);
		if (cnt != 0)
			cnt <= cnt - 1;
		if (i_write)
		begin
			o_data <= i_data;
			cnt    <= 4;
		end
	end
endmodule

// >>> verification/strap_ctrl_tb.sv
// Self-checking bench for the strap and mode control block
`timescale 1ns/100ps
module strap_ctrl_tb;
	import strap_ctrl_pkg::*;
	logic        I_CLK = 0, I_RESET_N = 0, boot = 1, rsel = 1, pls = 1, hold = 1;
	logic        I_WR = 0, I_RD = 0, nv_wr, nv_done, rom, xref, xpls, hov, core_n;
	logic [3:0]  I_ADDR = 4'h0;
	logic [31:0] I_WDATA = 32'h0, rdat, baud, mset, freq, O_RDATA, val [3];
	logic [95:0] nv_in, nv_out;
	int          errors = 0, n_checks = 0, seed = 32'h55cd4f1e;
	always #20 I_CLK = ~I_CLK;
	strap_ctrl uut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_BOOT_SOURCE_SELECT(boot),
		.I_EXTERNAL_REF_SELECT(rsel), .I_PULSE_REF_SELECT(pls), .I_HOLDOVER_FORCE(hold),
		.I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
		.I_NV_DATA(nv_in), .O_NV_DATA(nv_out), .O_NV_WRITE(nv_wr), .I_NV_DONE(nv_done),
		.O_BOOT_FROM_ROM(rom), .O_USE_EXT_REF(xref), .O_USE_EXT_PULSE(xpls), .O_HOLDOVER(hov),
		.O_CORE_RESET_N(core_n), .O_BAUD(baud), .O_MSGSET(mset), .O_FREQ(freq));
	nv_store_model nvm (.i_clk(I_CLK), .i_write(nv_wr), .i_data(nv_out), .o_data(nv_in),
		.o_done(nv_done));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_ADDR  <= a;
		I_WDATA <= d;
		I_WR    <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD   <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1 rdat = O_RDATA;
	endtask
	// Pins must settle before release, so they are set by the caller first
	task automatic hard_reset(input int n);
		@(posedge I_CLK);
		I_RESET_N <= 1'b0;
		repeat (n) @(posedge I_CLK);
		I_RESET_N <= 1'b1;
		repeat (6) @(posedge I_CLK);
		#1;
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		#(5000 * 40);
		errors++;
		$display("ERROR %0t: watchdog expired", $time);
		final_report();
	end
	initial
	begin
		hard_reset(4);
		chk(freq, 32'h00000064);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge I_CLK);
			{boot, rsel} <= 2'(k);
			{pls, hold} <= 2'($random(seed));
			hard_reset(RESET_MIN_CYCLES);
			chk(core_n, 1);
			chk(rom, !boot);
			chk(xref, !rsel);
			@(posedge I_CLK);
			{boot, rsel, pls, hold} <= ~{boot, rsel, pls, hold};
			repeat (5) @(posedge I_CLK);
			#1;
			chk({rom, xref}, {boot, rsel});
			chk(xpls, !pls);
			chk(hov, !hold);
			$display("strap case %0d done", k);
		end
		for (int a = 0; a < 3; a++)
		begin
			val[a] = $random(seed);
			wr(4'(a), val[a]);
		end
		#1;
		chk(freq, val[2]);
		for (int a = 0; a < 3; a++)
		begin
			rd(4'(a));
			chk(rdat, val[a]);
		end
		rd(4'h9);
		chk(rdat, 0);
		wr(4'h3, 32'hffffffff);
		rd(4'h3);
		chk(rdat[5:4], 2'b01);
		chk(rdat[3:0], {!hold, !pls, rsel, boot});
		$display("command test done");
		wr(4'h4, 32'h0);
		rd(4'h3);
		chk(rdat[5], 1);
		wr(4'h2, 32'h1);
		repeat (8) @(posedge I_CLK);
		hard_reset(RESET_MIN_CYCLES);
		chk(baud, val[0]);
		chk(mset, val[1]);
		chk(freq, val[2]);
		$display("save test done");
		final_report();
	end
endmodule
bind strap_ctrl strap_ctrl_props chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
	.I_PULSE_REF_SELECT(I_PULSE_REF_SELECT), .I_HOLDOVER_FORCE(I_HOLDOVER_FORCE),
	.I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_NV_WRITE(O_NV_WRITE),
	.O_BOOT_FROM_ROM(O_BOOT_FROM_ROM), .O_USE_EXT_REF(O_USE_EXT_REF),
	.O_USE_EXT_PULSE(O_USE_EXT_PULSE), .O_HOLDOVER(O_HOLDOVER), .O_CORE_RESET_N(O_CORE_RESET_N));
